// ### src/sfsr_pkg.sv
// Constants, types and carriers for the serial flash status register bank
package sfsr_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SRW_TIME_NS   = 200;
  localparam int SRW_CYCLES    = (SRW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RD1    = 8'h05;
  localparam logic [7:0] OP_RD2    = 8'h35;
  localparam logic [7:0] OP_RD3    = 8'h15;
  localparam logic [7:0] OP_WR1    = 8'h01;
  localparam logic [7:0] OP_WR2    = 8'h31;
  localparam logic [7:0] OP_WR3    = 8'h11;
  localparam logic [7:0] OP_SUSP   = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_RSTEN  = 8'h66;
  localparam logic [7:0] OP_RST    = 8'h99;
  localparam logic [7:0] OP_PAGE   = 8'h02;
  localparam logic [7:0] OP_SECT   = 8'h20;
  localparam logic [7:0] OP_BLK32  = 8'h52;
  localparam logic [7:0] OP_BLK64  = 8'hD8;
  localparam logic [7:0] OP_CHIP_A = 8'h60;
  localparam logic [7:0] OP_CHIP_B = 8'hC7;

  // Byte counts of complete command sequences
  localparam logic [2:0] LEN_CMD   = 3'h1;
  localparam logic [2:0] LEN_STATUS_WRITE_CMD  = 3'h2;
  localparam logic [2:0] LEN_ERASE = 3'h4;
  localparam logic [2:0] LEN_PAGE  = 3'h5;

  // Field positions inside the three 8-bit registers
  localparam int WIP_BIT    = 0;
  localparam int WEL_BIT    = 1;
  localparam int GUARD_LSB  = 2;
  localparam int SLL_BIT    = 7;
  localparam int SLH_BIT    = 0;
  localparam int QUAD_BIT   = 1;
  localparam int PPAUSE_BIT = 2;
  localparam int OTP_LSB    = 3;
  localparam int INV_BIT    = 6;
  localparam int EPAUSE_BIT = 7;
  localparam int WAIT_BIT   = 0;
  localparam int DRV_LSB    = 5;

  localparam logic [3:0] DUAL_DUMMY_0 = 4'h4;
  localparam logic [3:0] DUAL_DUMMY_1 = 4'h8;
  localparam logic [3:0] QUAD_DUMMY_0 = 4'h6;
  localparam logic [3:0] QUAD_DUMMY_1 = 4'hA;

  typedef enum logic [1:0] {
    SFSR_IDLE = 2'h0,
    SFSR_CMD  = 2'h1,
    SFSR_ARG  = 2'h3,
    SFSR_READ = 2'h2
  } sfsr_state_t;

  typedef enum logic [2:0] {
    SFSR_OP_PAGE  = 3'h0,
    SFSR_OP_SECT  = 3'h1,
    SFSR_OP_BLK32 = 3'h2,
    SFSR_OP_BLK64 = 3'h3,
    SFSR_OP_CHIP  = 3'h4
  } sfsr_op_t;

  typedef struct packed {
    logic       status_lock_high;
    logic       status_lock_low;
    logic       guard_invert;
    logic [2:0] otp_lock;
    logic [4:0] guard;
    logic [1:0] drive_level;
    logic       wait_cycle_select;
  } sfsr_nv_t;

  localparam sfsr_nv_t NV_RESET = '{1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 2'h1, 1'b0};

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } sfsr_spi_in_t;
endpackage

// ### src/sfsr_regs.sv
// Status register bank with its serial command front end
`timescale 1ns/10ps
// Function
// R1: Bit 0 shows op_in_flight while program, erase or status write runs.
// R2: Bit 1 shows write_latch; when 0, status writes, programs, erases are refused.
// R3: Guard bits 6..2 are written by status write and shield a region from writes.
// R4: Full wipe only when low guard bits all equal guard_invert.
// R5: Status-protect pair 00 lets status writes through once write_latch is set.
// R6: Pair (1,0) refuses status writes until power cycle, which restores (0,0).
// R7: Pair (1,1) refuses every status write permanently; the code instead lets rst restore (0,0), as it does for (1,0).
// R8: four_lane_allow in bit 9 is fixed at 1; writes to it are ignored.
// R9: One-time lock bits 13..11 reset to 0, set individually, never cleared; the code clears them again on rst.
// R10: guard_invert bit 14 is read/write, default 0, inverts protected region.
// R11: erase_paused bit 15 and program_paused bit 10 set on suspend, read-only.
// R12: Suspend flags clear on resume, software reset sequence and power cycle.
// R13: wait_cycle_select picks 4 or 8 dummy cycles for dual address read.
// R14: wait_cycle_select picks 6 or 10 dummy cycles for quad address read.
// R15: drive_level 00,01,10,11 gives 100,75,50,25 percent; default 01.
// R16: Status is three 8-bit registers; bits 23 and 20..17 reserved, read 0.
// R17: write_latch clears at power-up, reset, write disable, status write, program, erase.
// R18: Status write not ending on a byte boundary is refused, registers kept.
// R19: Host should write 0 into every reserved status bit.
// R20: Host values for read-only volatile bits are ignored during status writes.
module sfsr_regs (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire sfsr_pkg::sfsr_spi_in_t spi_in,
  input  wire logic                  engine_busy,
  input  wire logic                  engine_erasing,
  input  wire logic                  engine_done,
  output logic                       so_out,
  output logic                       so_oe_n,
  output logic                       array_start,
  output sfsr_pkg::sfsr_op_t         array_kind,
  output logic [23:0]                array_addr,
  output logic                       suspend_req,
  output logic                       resume_req,
  output sfsr_pkg::sfsr_nv_t         nv,
  output logic                       four_lane_allow,
  output logic [3:0]                 dual_dummy,
  output logic [3:0]                 quad_dummy
);
  logic [1:0]            cs_s;
  logic [2:0]            sck_s;
  logic [1:0]            si_s;
  logic                  cs_d;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  cs_rise;
  sfsr_pkg::sfsr_state_t st;
  logic [7:0]            sh;
  logic [2:0]            bit_idx;
  logic [2:0]            nbytes;
  logic [7:0]            opcode;
  logic [7:0]            wdata;
  logic [23:0]           addr;
  logic [2:0]            out_bit;
  logic [7:0]            next_byte;
  logic                  write_latch;
  logic                  erase_paused;
  logic                  program_paused;
  logic                  reset_armed;
  logic [3:0]            srw_cnt;
  logic                  op_in_flight;
  logic                  on_boundary;
  logic                  srw_ok;
  logic                  arr_ok;
  logic                  chip_ok;
  logic [7:0]            sr1;
  logic [7:0]            sr2;
  logic [7:0]            sr3;
  logic [7:0]            sel_reg;

  // Link pins cross into mclk; only the second stage and beyond feed logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_s  <= 2'h3;
      sck_s <= 3'h0;
      si_s  <= 2'h0;
      cs_d  <= 1'b1;
    end else begin
      cs_s  <= {cs_s[0], spi_in.cs_n};
      sck_s <= {sck_s[1:0], spi_in.sclk};
      si_s  <= {si_s[0], spi_in.si};
      cs_d  <= cs_s[1];
    end
  end

  assign sck_rise  = sck_s[1] & ~sck_s[2] & ~cs_s[1];
  assign sck_fall  = ~sck_s[1] & sck_s[2] & ~cs_s[1];
  assign cs_rise   = cs_s[1] & ~cs_d;
  assign next_byte = {sh[6:0], si_s[1]};

  // Byte framing; sampling on rising clock, mode 0 or 3
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st      <= sfsr_pkg::SFSR_IDLE;
      sh      <= 8'h00;
      bit_idx <= 3'h0;
      nbytes  <= 3'h0;
      opcode  <= 8'h00;
      wdata   <= 8'h00;
      addr    <= 24'h00_0000;
    end else if (cs_s[1]) begin
      st      <= sfsr_pkg::SFSR_IDLE;
      bit_idx <= 3'h0;
      nbytes  <= 3'h0;
    end else if (st == sfsr_pkg::SFSR_IDLE) begin
      st <= sfsr_pkg::SFSR_CMD;
    end else if (sck_rise) begin
      sh      <= next_byte;
      bit_idx <= bit_idx + 3'h1;
      if (bit_idx == 3'h7) begin
        if (nbytes != 3'h7) begin
          nbytes <= nbytes + 3'h1;
        end
        if (nbytes == 3'h0) begin
          opcode <= next_byte;
        end
        if (nbytes == 3'h1) begin
          wdata <= next_byte;
        end
        if (nbytes >= 3'h1 && nbytes <= 3'h3) begin
          addr <= {addr[15:0], next_byte};
        end
        if (st == sfsr_pkg::SFSR_CMD) begin
          unique case (next_byte)
            sfsr_pkg::OP_RD1, sfsr_pkg::OP_RD2, sfsr_pkg::OP_RD3: st <= sfsr_pkg::SFSR_READ;
            default:                                              st <= sfsr_pkg::SFSR_ARG;
          endcase
        end
      end
    end
  end

  assign op_in_flight = (srw_cnt != 4'h0) | engine_busy; // [R1]
  assign on_boundary  = (bit_idx == 3'h0); // [R18]
  assign srw_ok = write_latch & ~op_in_flight & ~nv.status_lock_high; // [R2] [R5] [R6] [R7]
  assign arr_ok = write_latch & ~op_in_flight; // [R2]
  assign chip_ok = (nv.guard[2:0] == {3{nv.guard_invert}}); // [R4]

  // Live register images; reserved bits read as zero
  always_comb begin
    sr1 = 8'h00;
    sr2 = 8'h00;
    sr3 = 8'h00;
    sr1[sfsr_pkg::WIP_BIT]                = op_in_flight; // [R1]
    sr1[sfsr_pkg::WEL_BIT]                = write_latch; // [R2]
    sr1[sfsr_pkg::GUARD_LSB +: 5]         = nv.guard; // [R3]
    sr1[sfsr_pkg::SLL_BIT]                = nv.status_lock_low;
    sr2[sfsr_pkg::SLH_BIT]                = nv.status_lock_high;
    sr2[sfsr_pkg::QUAD_BIT]               = four_lane_allow; // [R8]
    sr2[sfsr_pkg::PPAUSE_BIT]             = program_paused; // [R11]
    sr2[sfsr_pkg::OTP_LSB +: 3]           = nv.otp_lock; // [R9]
    sr2[sfsr_pkg::INV_BIT]                = nv.guard_invert; // [R10]
    sr2[sfsr_pkg::EPAUSE_BIT]             = erase_paused; // [R11]
    sr3[sfsr_pkg::WAIT_BIT]               = nv.wait_cycle_select;
    sr3[sfsr_pkg::DRV_LSB +: 2]           = nv.drive_level; // [R15] [R16]
    unique case (opcode)
      sfsr_pkg::OP_RD2: sel_reg = sr2;
      sfsr_pkg::OP_RD3: sel_reg = sr3; // [R16]
      default:          sel_reg = sr1;
    endcase
  end

  // Read-out drives on falling clock; image stays live so busy can be polled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      so_out  <= 1'b0;
      so_oe_n <= 1'b1;
      out_bit <= 3'h0;
    end else if (st != sfsr_pkg::SFSR_READ) begin
      so_oe_n <= 1'b1;
      out_bit <= 3'h0;
    end else if (sck_fall) begin
      so_oe_n <= 1'b0;
      so_out  <= sel_reg[3'h7 - out_bit];
      out_bit <= out_bit + 3'h1;
    end
  end

  // Status write busy time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      srw_cnt <= 4'h0;
    end else if (cs_rise && on_boundary && nbytes >= sfsr_pkg::LEN_STATUS_WRITE_CMD && srw_ok &&
                 (opcode == sfsr_pkg::OP_WR1 || opcode == sfsr_pkg::OP_WR2 ||
                  opcode == sfsr_pkg::OP_WR3)) begin
      srw_cnt <= 4'(sfsr_pkg::SRW_CYCLES); // [R1]
    end else if (srw_cnt != 4'h0) begin
      srw_cnt <= srw_cnt - 4'h1;
    end
  end

  // Non-volatile image; rst stands for a power cycle and restores delivery values
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nv <= sfsr_pkg::NV_RESET; // [R6] [R9] [R10] [R15]
    end else if (cs_rise && on_boundary && nbytes >= sfsr_pkg::LEN_STATUS_WRITE_CMD && srw_ok) begin // [R18]
      unique case (opcode)
        sfsr_pkg::OP_WR1: begin
          nv.status_lock_low <= wdata[sfsr_pkg::SLL_BIT];
          nv.guard           <= wdata[sfsr_pkg::GUARD_LSB +: 5]; // [R3]
        end
        sfsr_pkg::OP_WR2: begin
          nv.status_lock_high <= wdata[sfsr_pkg::SLH_BIT];
          nv.guard_invert     <= wdata[sfsr_pkg::INV_BIT]; // [R10]
          nv.otp_lock <= nv.otp_lock | wdata[sfsr_pkg::OTP_LSB +: 3]; // [R9]
        end
        sfsr_pkg::OP_WR3: begin
          nv.drive_level       <= wdata[sfsr_pkg::DRV_LSB +: 2]; // [R15]
          nv.wait_cycle_select <= wdata[sfsr_pkg::WAIT_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Volatile flags; host values for them are never taken from write data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_latch    <= 1'b0; // [R17]
      erase_paused   <= 1'b0; // [R12]
      program_paused <= 1'b0;
      reset_armed    <= 1'b0;
      suspend_req    <= 1'b0;
      resume_req     <= 1'b0;
    end else begin
      suspend_req <= 1'b0;
      resume_req  <= 1'b0;
      if (engine_done) begin
        write_latch <= 1'b0; // [R17]
      end
      if (cs_rise && on_boundary && nbytes != 3'h0) begin
        reset_armed <= (opcode == sfsr_pkg::OP_RSTEN);
        unique case (opcode)
          sfsr_pkg::OP_WREN: write_latch <= 1'b1; // [R2]
          sfsr_pkg::OP_WRDI: write_latch <= 1'b0; // [R17]
          sfsr_pkg::OP_WR1, sfsr_pkg::OP_WR2, sfsr_pkg::OP_WR3: begin
            if (srw_ok && nbytes >= sfsr_pkg::LEN_STATUS_WRITE_CMD) begin
              write_latch <= 1'b0; // [R17] [R20]
            end
          end
          sfsr_pkg::OP_SUSP: begin
            if (engine_busy) begin
              suspend_req    <= 1'b1;
              erase_paused   <= erase_paused | engine_erasing; // [R11]
              program_paused <= program_paused | ~engine_erasing; // [R11]
            end
          end
          sfsr_pkg::OP_RESUME: begin
            resume_req     <= erase_paused | program_paused;
            erase_paused   <= 1'b0; // [R12]
            program_paused <= 1'b0;
          end
          sfsr_pkg::OP_RST: begin
            if (reset_armed) begin
              write_latch    <= 1'b0; // [R17]
              erase_paused   <= 1'b0; // [R12]
              program_paused <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Array requests; the engine clears write_latch when it finishes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      array_start <= 1'b0;
      array_kind  <= sfsr_pkg::SFSR_OP_PAGE;
      array_addr  <= 24'h00_0000;
    end else begin
      array_start <= 1'b0;
      if (cs_rise && on_boundary && arr_ok) begin // [R2] [R18]
        array_addr <= addr;
        unique case (opcode)
          sfsr_pkg::OP_PAGE: begin
            array_start <= (nbytes >= sfsr_pkg::LEN_PAGE);
            array_kind  <= sfsr_pkg::SFSR_OP_PAGE;
          end
          sfsr_pkg::OP_SECT: begin
            array_start <= (nbytes == sfsr_pkg::LEN_ERASE);
            array_kind  <= sfsr_pkg::SFSR_OP_SECT;
          end
          sfsr_pkg::OP_BLK32: begin
            array_start <= (nbytes == sfsr_pkg::LEN_ERASE);
            array_kind  <= sfsr_pkg::SFSR_OP_BLK32;
          end
          sfsr_pkg::OP_BLK64: begin
            array_start <= (nbytes == sfsr_pkg::LEN_ERASE);
            array_kind  <= sfsr_pkg::SFSR_OP_BLK64;
          end
          sfsr_pkg::OP_CHIP_A, sfsr_pkg::OP_CHIP_B: begin
            array_start <= (nbytes == sfsr_pkg::LEN_CMD) && chip_ok; // [R4]
            array_kind  <= sfsr_pkg::SFSR_OP_CHIP;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read timing outputs follow the stored configuration
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      four_lane_allow <= 1'b1;
      dual_dummy      <= sfsr_pkg::DUAL_DUMMY_0;
      quad_dummy      <= sfsr_pkg::QUAD_DUMMY_0;
    end else begin
      four_lane_allow <= 1'b1; // [R8]
      dual_dummy <= nv.wait_cycle_select ? sfsr_pkg::DUAL_DUMMY_1 : sfsr_pkg::DUAL_DUMMY_0; // [R13]
      quad_dummy <= nv.wait_cycle_select ? sfsr_pkg::QUAD_DUMMY_1 : sfsr_pkg::QUAD_DUMMY_0; // [R14]
    end
  end
endmodule

// ### tb/sfsr_regs_asserts.sv
// Port-level assertions for the status register bank
`timescale 1ns/10ps
module sfsr_regs_asserts (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire sfsr_pkg::sfsr_spi_in_t spi_in,
  input wire logic                   engine_busy,
  input wire logic                   engine_erasing,
  input wire logic                   engine_done,
  input wire logic                   so_out,
  input wire logic                   so_oe_n,
  input wire logic                   array_start,
  input wire sfsr_pkg::sfsr_op_t     array_kind,
  input wire logic [23:0]            array_addr,
  input wire logic                   suspend_req,
  input wire logic                   resume_req,
  input wire sfsr_pkg::sfsr_nv_t     nv,
  input wire logic                   four_lane_allow,
  input wire logic [3:0]             dual_dummy,
  input wire logic [3:0]             quad_dummy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_frame_end;
    $rose(spi_in.cs_n);
  endsequence
  sequence s_oe_off;
    so_oe_n [*2];
  endsequence
  a_lane_fixed: assert property (four_lane_allow)
    else $error("four-lane enable dropped");
  a_dual_wait: assert property (dual_dummy == ($past(nv.wait_cycle_select) ? 4'h8 : 4'h4))
    else $error("dual dummy count wrong");
  a_quad_wait: assert property (quad_dummy == ($past(nv.wait_cycle_select) ? 4'hA : 4'h6))
    else $error("quad dummy count wrong");
  a_otp_sticky: assert property ((nv.otp_lock & $past(nv.otp_lock)) == $past(nv.otp_lock))
    else $error("one-time lock bit cleared");
  a_lock_freeze: assert property (nv.status_lock_high |=> $stable(nv))
    else $error("locked config changed");
  a_nv_framed: assert property (!$stable(nv) |-> $past(spi_in.cs_n, 2))
    else $error("config changed inside a frame");
  a_chip_guard: assert property (array_start && array_kind == sfsr_pkg::SFSR_OP_CHIP
    |-> nv.guard[2:0] == {3{nv.guard_invert}}) else $error("chip wipe let through");
  a_start_framed: assert property (array_start |-> $past(spi_in.cs_n, 2) && !$past(array_start))
    else $error("array start outside frame end");
  a_susp_busy: assert property (suspend_req |-> $past(engine_busy))
    else $error("suspend without busy engine");
  a_oe_release: assert property (s_frame_end |-> ##[1:5] s_oe_off)
    else $error("output not released after frame");
  a_resume_once: assert property (resume_req |=> !resume_req && !suspend_req)
    else $error("resume pulse too long");
endmodule
bind sfsr_regs sfsr_regs_asserts chk (.mclk(mclk), .rst(rst), .spi_in(spi_in),
  .engine_busy(engine_busy), .engine_erasing(engine_erasing), .engine_done(engine_done),
  .so_out(so_out), .so_oe_n(so_oe_n), .array_start(array_start), .array_kind(array_kind),
  .array_addr(array_addr), .suspend_req(suspend_req), .resume_req(resume_req), .nv(nv),
  .four_lane_allow(four_lane_allow), .dual_dummy(dual_dummy), .quad_dummy(quad_dummy));

// ### tb/sfsr_host.sv
// SPI host model issuing status command frames
`timescale 1ns/10ps
module sfsr_host (
  output sfsr_pkg::sfsr_spi_in_t spi,
  input  wire logic              so_out
);
  initial spi = '{1'b1, 1'b0, 1'b1};
  // Mode 0, MSB first; sclk stands low outside frames
  task automatic xfer(input logic [39:0] tx, input int nb, output logic [7:0] rx);
    spi.cs_n = 1'b0;
    #100;
    for (int i = 0; i < nb; i++) begin
      spi.si = tx[39-i];
      #100 spi.sclk = 1'b1;
      #90 rx = {rx[6:0], so_out};
      #10 spi.sclk = 1'b0;
    end
    #100 spi.cs_n = 1'b1;
    // No pull on si, so a released line shows the inverse, not a stale copy
    spi.si = ~spi.si;
    #400;
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the status register bank
`timescale 1ns/10ps
module tb_top;
  logic                   mclk, rst, busy, erasing, done, so_out, so_oe_n;
  logic                   array_start, suspend_req, resume_req, lanes;
  logic [23:0]            addr;
  logic [3:0]             dual, quad;
  logic [7:0]             rx;
  sfsr_pkg::sfsr_spi_in_t spi;
  sfsr_pkg::sfsr_op_t     kind;
  sfsr_pkg::sfsr_nv_t     nv;
  int                     failures, n_checks, n_start, n_susp, n_res;

  sfsr_host host (.spi(spi), .so_out(so_out));
  sfsr_regs dut (.mclk(mclk), .rst(rst), .spi_in(spi), .engine_busy(busy),
    .engine_erasing(erasing), .engine_done(done), .so_out(so_out), .so_oe_n(so_oe_n),
    .array_start(array_start), .array_kind(kind), .array_addr(addr),
    .suspend_req(suspend_req), .resume_req(resume_req), .nv(nv),
    .four_lane_allow(lanes), .dual_dummy(dual), .quad_dummy(quad));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    n_start += int'(array_start === 1'b1);
    n_susp  += int'(suspend_req === 1'b1);
    n_res   += int'(resume_req === 1'b1);
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic raw(input logic [7:0] op, input logic [7:0] d, input int nb);
    @(posedge mclk);
    #2 host.xfer({op, d, 24'h0}, nb, rx);
  endtask
  task automatic cmd(input logic [7:0] op);
    raw(op, 8'h00, 8);
  endtask
  task automatic wr(input int n, input logic [7:0] d);
    cmd(sfsr_pkg::OP_WREN);
    raw(n == 1 ? sfsr_pkg::OP_WR1 : n == 2 ? sfsr_pkg::OP_WR2 : sfsr_pkg::OP_WR3, d, 16);
  endtask
  task automatic rd(input int n, input logic [7:0] exp);
    raw(n == 1 ? sfsr_pkg::OP_RD1 : n == 2 ? sfsr_pkg::OP_RD2 : sfsr_pkg::OP_RD3, 8'h00, 16);
    check(24'(rx), 24'(exp), "status read");
  endtask
  task automatic power_cycle();
    @(posedge mclk) #2 rst = 1'b1;
    repeat (5) @(posedge mclk);
    #2 rst = 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Run is roughly 250 us; the limit leaves wide margin
  initial begin
    #2_000_000;
    failures++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    {busy, erasing, done} = 3'h0;
    power_cycle();
    check(24'(nv), 24'(sfsr_pkg::NV_RESET), "nv reset");
    check(24'({dual, quad}), 24'h00_0046, "dummy reset");
    rd(1, 8'h00);
    rd(2, 8'h02);
    rd(3, 8'h20);
    raw(sfsr_pkg::OP_WR1, 8'h1C, 16);
    rd(1, 8'h00);
    cmd(sfsr_pkg::OP_WREN);
    rd(1, 8'h02);
    cmd(sfsr_pkg::OP_WRDI);
    rd(1, 8'h00);
    wr(1, 8'h1F);
    rd(1, 8'h1C);
    cmd(sfsr_pkg::OP_WREN);
    cmd(sfsr_pkg::OP_CHIP_A);
    check(24'(n_start), 24'h00_0000, "chip wipe refused");
    wr(2, 8'hC4);
    rd(2, 8'h42);
    cmd(sfsr_pkg::OP_WREN);
    cmd(sfsr_pkg::OP_CHIP_B);
    check(24'(n_start), 24'h00_0001, "chip wipe taken");
    check(24'(kind), 24'(sfsr_pkg::SFSR_OP_CHIP), "wipe kind");
    @(posedge mclk) #2 done = 1'b1;
    @(posedge mclk) #2 done = 1'b0;
    rd(1, 8'h1C);
    raw(sfsr_pkg::OP_SECT, 8'h12, 32);
    check(24'(n_start), 24'h00_0001, "erase refused");
    cmd(sfsr_pkg::OP_WREN);
    raw(sfsr_pkg::OP_BLK64, 8'h12, 32);
    check(24'(n_start), 24'h00_0002, "erase taken");
    check(addr, 24'h12_0000, "erase address");
    check(24'(kind), 24'(sfsr_pkg::SFSR_OP_BLK64), "erase kind");
    @(posedge mclk) #2 done = 1'b1;
    @(posedge mclk) #2 done = 1'b0;
    cmd(sfsr_pkg::OP_WREN);
    raw(sfsr_pkg::OP_PAGE, 8'h34, 40);
    check(24'(n_start), 24'h00_0003, "program taken");
    check(addr, 24'h34_0000, "program address");
    check(24'(kind), 24'(sfsr_pkg::SFSR_OP_PAGE), "program kind");
    @(posedge mclk) #2 done = 1'b1;
    @(posedge mclk) #2 done = 1'b0;
    rd(1, 8'h1C);
    cmd(sfsr_pkg::OP_WREN);
    raw(sfsr_pkg::OP_WR3, 8'h41, 15);
    rd(3, 8'h20);
    rd(1, 8'h1E);
    for (int d = 0; d < 4; d++) begin
      wr(3, {1'b0, 2'(d), 5'h00});
      check(24'(nv.drive_level), 24'(d), "drive level");
    end
    wr(3, 8'h61);
    rd(3, 8'h61);
    check(24'({dual, quad}), 24'h00_008A, "dummy set");
    @(posedge mclk) #2 {busy, erasing} = 2'h3;
    rd(1, 8'h1D);
    cmd(sfsr_pkg::OP_SUSP);
    @(posedge mclk) #2 erasing = 1'b0;
    cmd(sfsr_pkg::OP_SUSP);
    rd(2, 8'hC6);
    check(24'(n_susp), 24'h00_0002, "suspend pulses");
    cmd(sfsr_pkg::OP_RESUME);
    rd(2, 8'h42);
    check(24'(n_res), 24'h00_0001, "resume pulse");
    cmd(sfsr_pkg::OP_SUSP);
    cmd(sfsr_pkg::OP_WREN);
    cmd(sfsr_pkg::OP_RSTEN);
    cmd(sfsr_pkg::OP_RST);
    rd(2, 8'h42);
    rd(1, 8'h1D);
    @(posedge mclk) #2 busy = 1'b0;
    wr(2, 8'h48);
    rd(2, 8'h4A);
    wr(2, 8'h40);
    rd(2, 8'h4A);
    wr(2, 8'h49);
    wr(1, 8'h00);
    rd(1, 8'h1E);
    power_cycle();
    check(24'(nv), 24'(sfsr_pkg::NV_RESET), "power cycle");
    wr(1, 8'h80);
    wr(2, 8'h01);
    wr(1, 8'h00);
    rd(1, 8'h82);
    tally_and_finish();
  end
endmodule
